// ---- pipeline_hazard_interlock.v ----
// Four-stage pipeline interlock: register hazards and memory conflicts
// Notes on behaviour
// - Address registers fall into auxiliary, page and stack groups.
// - Decode waits on a group until its writer finishes execute.
// - Auxiliary load then auxiliary address use costs two decode cycles.
// - Decode stall cycles refetch the next program word when fetch is ready and unblocked, except a busy-port stall's first cycle.
// - Operand read of a group stalls next decode use one cycle.
// - No read stall for index, block size or page registers.
// - Loop counter use by decrement-branch counts as address use.
// - Internal RAM and ROM blocks take two accesses per cycle.
// - External interface takes one access per cycle.
// - Fetch waits when two data accesses fill its internal block.
// - Fetch waits when its external port starts a data access.
// - Multicycle external access runs to end; fetch waits for it.
// - Wait-state fetch holds fetch stage until memory is ready.
// - Store in execute then dual read: only execute proceeds.
// - Double store then any read: read waits one cycle.
// - Interlocked load extends read while external flag is one.
// - Access to a busy port retries, freezing the pipeline.
// - First dummy fetch of busy-port stall meets second decode cycle.
// - Multicycle external load freezes all stages until done.
// - Conditional call or trap holds every stage.
// - Priority execute, read, decode, fetch, then DMA.
// - Decode owns auxiliary and stack pointer updates.
`timescale 1ns/1ps
`default_nettype none
`include "interlock_consts.vh"
module pipeline_hazard_interlock (
  input wire clk_sys,
  input wire reset_n,
  // Decode-stage instruction description
  input wire decValid,
  input wire [`REG_W-1:0] decUseReg,
  input wire decUseValid,
  input wire decIsLoop,
  input wire [`REG_W-1:0] decWriteReg,
  input wire decWriteValid,
  input wire [`REG_W-1:0] decReadReg,
  input wire decReadValid,
  input wire decDualRead,
  input wire decAnyRead,
  input wire decSingleStore,
  input wire decDoubleStore,
  input wire decInterlockLoad,
  input wire decCondCallTrap,
  input wire [`RES_W-1:0] decDataResA,
  input wire [`RES_W-1:0] decDataResB,
  // Fetch request and memory handshakes
  input wire fetchReq,
  input wire [`RES_W-1:0] fetchRes,
  input wire fetchReady,
  input wire extDataDone,
  input wire dmaMultiActive,
  input wire [`RES_W-1:0] dmaRes,
  input wire external_flag_one,
  // Stage controls
  output reg fetchAdvance_r,
  output reg fetchRefetch_r,
  output reg decodeAdvance_r,
  output reg readAdvance_r,
  output reg executeAdvance_r,
  output reg decodeBubble_r,
  output reg readBubble_r,
  output reg executeBubble_r,
  output reg decodeAddrUpdate_r,
  output reg dmaGrant_r
);
  // Pipeline tracking of instructions in read and execute
  reg [`GRP_W-1:0] rdWrGrp_r, exWrGrp_r;
  reg rdRdStall_r;
  reg [`GRP_W-1:0] rdRdGrp_r;
  reg rdAuxLoad_r;
  reg rdDual_r, rdAny_r, rdIlock_r, rdCall_r;
  reg exSingleStore_r, exDoubleStore_r, exCall_r;
  reg rdSingle_r, rdDouble_r;
  reg [`RES_W-1:0] rdResA_r, rdResB_r;
  reg [`RES_W-1:0] busyPort_r;
  reg extWait_r;
  reg [1:0] auxCnt_r, auxCnt_nxt;
  reg busyFirst_r;
  wire [`GRP_W-1:0] useGrp, wrGrp, rdGrp;
  wire rdStalls;
  wire fetchBlocked, dataConflict;
  wire [`RES_W-1:0] busyArb;
  // Address-use, write and read classification
  hazard_group_classify uUse (
    .regIdx(decUseReg),
    .regValid(decUseValid | decIsLoop),
    .group(useGrp),
    .readStalls()
  );
  hazard_group_classify uWr (
    .regIdx(decWriteReg),
    .regValid(decWriteValid),
    .group(wrGrp),
    .readStalls()
  );
  hazard_group_classify uRd (
    .regIdx(decReadReg),
    .regValid(decReadValid),
    .group(rdGrp),
    .readStalls(rdStalls)
  );
  // Busy port seen by fetch: ours or a running DMA burst
  assign busyArb = extWait_r ? busyPort_r :
    (dmaMultiActive ? dmaRes : `RES_NONE);
  mem_port_arbiter uArb (
    .dataResA(rdResA_r),
    .dataResB(rdResB_r),
    .fetchRes(fetchRes),
    .fetchReq(fetchReq),
    .busyPort(busyArb),
    .fetchBlocked(fetchBlocked),
    .dataConflict(dataConflict)
  );
  function isExtRes;
    input [`RES_W-1:0] r;
    begin
      isExtRes = (r == `RES_PRI) || (r == `RES_EXP);
    end
  endfunction
  // Stall terms
  reg holdAll, execOnly, readHold, decStall, fetchStall;
  reg grpWriteHaz, grpReadHaz, busyHit, auxHaz;
  always @* begin
    // Data access to a port still finishing an earlier access
    busyHit = extWait_r && ((rdResA_r == busyPort_r) ||
      (rdResB_r == busyPort_r)) && !extDataDone;
    // Every stage frozen: busy port, long external load, call/trap
    holdAll = busyHit || (extWait_r && !extDataDone) ||
      exCall_r;
    // Only execute proceeds on three data accesses, an external port conflict or interlock
    execOnly = (exSingleStore_r && rdDual_r) ||
      (exDoubleStore_r && rdAny_r) ||
      (rdIlock_r && external_flag_one) ||
      dataConflict;
    readHold = holdAll || execOnly;
    // Group written by read or execute instruction blocks decode use
    grpWriteHaz = (useGrp != `GRP_NONE) &&
      ((useGrp == rdWrGrp_r) || (useGrp == exWrGrp_r));
    // Operand read in read stage blocks next decode use once
    grpReadHaz = (useGrp != `GRP_NONE) && rdRdStall_r &&
      (useGrp == rdRdGrp_r);
    auxHaz = (auxCnt_r != 2'h0) && (useGrp == `GRP_AUX);
    decStall = decValid && (grpWriteHaz || grpReadHaz || auxHaz);
    // Lower units wait whenever the unit above cannot accept
    decStall = decStall || readHold;
    fetchStall = decStall || fetchBlocked || !fetchReady;
  end
  // Extra decode delay counter after an auxiliary load
  always @* begin
    auxCnt_nxt = auxCnt_r;
    // Writer sitting in read already costs the first of the two cycles
    if (rdAuxLoad_r && !readHold)
      auxCnt_nxt = `AUX_LOAD_STALL - 2'h1;
    else if (auxCnt_r != 2'h0)
      auxCnt_nxt = auxCnt_r - 2'h1;
  end
  // Stage advance, bubbles and refetch strobes
  always @(posedge clk_sys) begin
    if (!reset_n) begin
      fetchAdvance_r <= 1'b0;
      fetchRefetch_r <= 1'b0;
      decodeAdvance_r <= 1'b0;
      readAdvance_r <= 1'b0;
      executeAdvance_r <= 1'b0;
      decodeBubble_r <= 1'b0;
      readBubble_r <= 1'b0;
      executeBubble_r <= 1'b0;
      decodeAddrUpdate_r <= 1'b0;
      dmaGrant_r <= 1'b0;
      busyFirst_r <= 1'b0;
    end else begin
      executeAdvance_r <= !holdAll;
      readAdvance_r <= !readHold;
      executeBubble_r <= readHold && !holdAll;
      decodeAdvance_r <= !decStall;
      readBubble_r <= decStall && !readHold;
      // Address generation happens only when decode moves on
      decodeAddrUpdate_r <= !decStall && decValid;
      fetchAdvance_r <= !fetchStall;
      decodeBubble_r <= !decStall && fetchStall;
      // Busy-port freeze skips refetch on its first decode cycle
      busyFirst_r <= busyHit;
      fetchRefetch_r <= decStall && fetchReady && !fetchBlocked &&
        !(busyHit && !busyFirst_r);
      // DMA only takes what the CPU leaves free
      dmaGrant_r <= !(fetchReq && !fetchStall) && !readHold;
    end
  end
  // Track instruction attributes moving through read and execute
  always @(posedge clk_sys) begin
    if (!reset_n) begin
      rdWrGrp_r <= `GRP_NONE;
      exWrGrp_r <= `GRP_NONE;
      rdRdStall_r <= 1'b0;
      rdRdGrp_r <= `GRP_NONE;
      rdAuxLoad_r <= 1'b0;
      rdDual_r <= 1'b0;
      rdAny_r <= 1'b0;
      rdIlock_r <= 1'b0;
      rdCall_r <= 1'b0;
      rdSingle_r <= 1'b0;
      rdDouble_r <= 1'b0;
      exSingleStore_r <= 1'b0;
      exDoubleStore_r <= 1'b0;
      exCall_r <= 1'b0;
      rdResA_r <= `RES_NONE;
      rdResB_r <= `RES_NONE;
      busyPort_r <= `RES_NONE;
      extWait_r <= 1'b0;
      auxCnt_r <= 2'h0;
    end else begin
      auxCnt_r <= auxCnt_nxt;
      if (!holdAll) begin
        // Execute takes the read instruction or a bubble
        exWrGrp_r <= readHold ? `GRP_NONE : rdWrGrp_r;
        exSingleStore_r <= !readHold && rdSingle_r;
        exDoubleStore_r <= !readHold && rdDouble_r;
        exCall_r <= !readHold && rdCall_r;
      end else if (exCall_r) begin
        exCall_r <= 1'b0; // Call store occupies one extra cycle
      end
      if (!readHold) begin
        // Read stage loads decode instruction or a bubble
        rdWrGrp_r <= decStall ? `GRP_NONE : wrGrp;
        rdRdGrp_r <= decStall ? `GRP_NONE : rdGrp;
        rdRdStall_r <= !decStall && rdStalls;
        rdAuxLoad_r <= !decStall && decWriteValid &&
          (decWriteReg <= `REG_AR_LAST);
        rdDual_r <= !decStall && decDualRead;
        rdAny_r <= !decStall && decAnyRead;
        rdIlock_r <= !decStall && decInterlockLoad;
        rdCall_r <= !decStall && decCondCallTrap;
        rdResA_r <= decStall ? `RES_NONE : decDataResA;
        rdResB_r <= decStall ? `RES_NONE : decDataResB;
        // Stores pass through read before they occupy execute
        rdSingle_r <= !decStall && decSingleStore;
        rdDouble_r <= !decStall && decDoubleStore;
      end else begin
        rdRdStall_r <= 1'b0; // Read stall lasts one cycle only
      end
      // External access stays open until the port reports done
      if (extWait_r) begin
        if (extDataDone)
          extWait_r <= 1'b0;
      end else if (!readHold && isExtRes(rdResA_r) && !extDataDone) begin
        extWait_r <= 1'b1;
        busyPort_r <= rdResA_r;
      end
    end
  end
endmodule
`default_nettype wire

// ---- interlock_consts.vh ----
// Constants shared by the pipeline interlock files
`ifndef INTERLOCK_CONSTS_VH
`define INTERLOCK_CONSTS_VH
// Hazard group codes
`define GRP_W 2
`define GRP_NONE 2'h0
`define GRP_AUX 2'h1
`define GRP_PAGE 2'h2
`define GRP_STACK 2'h3
// Memory resource codes
`define RES_W 3
`define RES_NONE 3'h0
`define RES_RAM0 3'h1
`define RES_RAM1 3'h2
`define RES_ROM 3'h3
`define RES_PRI 3'h4
`define RES_EXP 3'h5
// Port limits per cycle
`define INT_PORTS 2'h2
`define EXT_PORTS 2'h1
// Extra decode cycles after an auxiliary load
`define AUX_LOAD_STALL 2'h2
// Register index codes for classification
`define REG_W 5
`define REG_AR_LAST 5'h07
`define REG_IDX0 5'h08
`define REG_IDX1 5'h09
`define REG_BLK 5'h0a
`define REG_DP 5'h0b
`define REG_SP 5'h0c
`endif

// ---- hazard_group_classify.v ----
// Maps a register index onto its address hazard group
`timescale 1ns/1ps
`default_nettype none
`include "interlock_consts.vh"
module hazard_group_classify (
  input wire [`REG_W-1:0] regIdx,
  input wire regValid,
  output reg [`GRP_W-1:0] group,
  output reg readStalls
);
  // Group decode; index, block size and page reads never stall
  always @* begin
    group = `GRP_NONE;
    readStalls = 1'b0;
    if (regValid) begin
      if (regIdx <= `REG_BLK) begin
        group = `GRP_AUX;
        readStalls = (regIdx <= `REG_AR_LAST);
      end else if (regIdx == `REG_DP) begin
        group = `GRP_PAGE;
      end else if (regIdx == `REG_SP) begin
        group = `GRP_STACK;
        readStalls = 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// ---- mem_port_arbiter.v ----
// Per-cycle memory bandwidth check for fetch and data accesses
`timescale 1ns/1ps
`default_nettype none
`include "interlock_consts.vh"
module mem_port_arbiter (
  input wire [`RES_W-1:0] dataResA,
  input wire [`RES_W-1:0] dataResB,
  input wire [`RES_W-1:0] fetchRes,
  input wire fetchReq,
  input wire [`RES_W-1:0] busyPort,
  output reg fetchBlocked,
  output reg dataConflict
);
  // Count of accesses one data operand puts on a resource
  function [1:0] hits;
    input [`RES_W-1:0] a;
    input [`RES_W-1:0] r;
    begin
      hits = (a == r && r != `RES_NONE) ? 2'h1 : 2'h0;
    end
  endfunction
  function isExt;
    input [`RES_W-1:0] r;
    begin
      isExt = (r == `RES_PRI) || (r == `RES_EXP);
    end
  endfunction
  reg [1:0] dataOnFetch;
  // Data wins the port; fetch waits when capacity is used up
  always @* begin
    dataOnFetch = hits(dataResA, fetchRes) + hits(dataResB, fetchRes);
    fetchBlocked = 1'b0;
    if (fetchReq) begin
      if (isExt(fetchRes)) begin
        if (dataOnFetch >= `EXT_PORTS)
          fetchBlocked = 1'b1;
        if (busyPort == fetchRes)
          fetchBlocked = 1'b1;
      end else if (fetchRes != `RES_NONE) begin
        if (dataOnFetch >= `INT_PORTS)
          fetchBlocked = 1'b1;
      end
    end
    // Two data accesses to one external port cannot share a cycle
    dataConflict = isExt(dataResA) && (dataResA == dataResB);
  end
endmodule
`default_nettype wire

// ---- mem_far_side.sv ----
// Behavioural memory, port and flag side for the interlock bench
`timescale 1ns/1ps
`default_nettype none
`include "interlock_consts.vh"
module mem_far_side #(
  parameter int FETCH_WAITS = 3,
  parameter int FLAG_CYCLES = 2,
  parameter int DMA_CYCLES = 3,
  parameter int DATA_CYCLES = 2
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic kickFetch,
  input wire logic kickFlag,
  input wire logic kickDma,
  input wire logic kickData,
  output logic fetchReady,
  output logic extDataDone,
  output logic dmaMultiActive,
  output logic [`RES_W-1:0] dmaRes,
  output logic external_flag_one
);
  int fetchCnt;
  int flagCnt;
  int dmaCnt;
  int dataCnt;
  function automatic int down(input int v);
    down = (v > 0) ? v - 1 : 0;
  endfunction
  // Counters reload on a kick; a DMA burst is never cut short
  always @(posedge clk_sys) begin
    if (!reset_n) begin
      fetchCnt <= 0;
      flagCnt <= 0;
      dmaCnt <= 0;
      dataCnt <= 0;
    end else begin
      fetchCnt <= kickFetch ? FETCH_WAITS : down(fetchCnt);
      flagCnt <= kickFlag ? FLAG_CYCLES : down(flagCnt);
      dmaCnt <= kickDma ? DMA_CYCLES : down(dmaCnt);
      dataCnt <= kickData ? DATA_CYCLES : down(dataCnt);
    end
  end
  assign fetchReady = (fetchCnt == 0);
  assign external_flag_one = (flagCnt != 0);
  assign dmaMultiActive = (dmaCnt != 0);
  assign dmaRes = dmaMultiActive ? `RES_PRI : `RES_NONE;
  // Port reports done on the last cycle of a burst or a slow data access
  assign extDataDone = (dmaCnt == 1) || (dataCnt == 1);
endmodule
`default_nettype wire

// ---- pipeline_hazard_interlock_checker.sv ----
// Concurrent checks on the interlock's stage controls
`timescale 1ns/1ps
`default_nettype none
`include "interlock_consts.vh"
module pipeline_hazard_interlock_checker (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic decValid,
  input wire logic [`REG_W-1:0] decUseReg,
  input wire logic decUseValid,
  input wire logic [`REG_W-1:0] decWriteReg,
  input wire logic decWriteValid,
  input wire logic decInterlockLoad,
  input wire logic decCondCallTrap,
  input wire logic [`RES_W-1:0] decDataResA,
  input wire logic [`RES_W-1:0] decDataResB,
  input wire logic fetchReq,
  input wire logic [`RES_W-1:0] fetchRes,
  input wire logic fetchReady,
  input wire logic dmaMultiActive,
  input wire logic [`RES_W-1:0] dmaRes,
  input wire logic external_flag_one,
  input wire logic fetchAdvance_r,
  input wire logic decodeAdvance_r,
  input wire logic readAdvance_r
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  // Aux load then aux address use, on consecutive cycles
  sequence auxWrite;
    decValid && decWriteValid && decWriteReg <= `REG_AR_LAST;
  endsequence
  // Use arrives just as the writer leaves decode
  sequence auxUse;
    decValid && decUseValid && decUseReg <= `REG_AR_LAST && decodeAdvance_r;
  endsequence
  // Two operands on one internal block, that block fetched a cycle later
  sequence blockFull;
    decValid && decDataResA != `RES_NONE && decDataResA <= `RES_ROM &&
      decDataResB == decDataResA ##1
      decodeAdvance_r && fetchReq && fetchRes == $past(decDataResA);
  endsequence
  // External operand reaches read while fetch wants the same port
  sequence extStart;
    decValid && (decDataResA == `RES_PRI || decDataResA == `RES_EXP) ##1
      decodeAdvance_r && fetchReq && fetchRes == $past(decDataResA);
  endsequence
  // Interlocked load in read with the flag still up
  sequence ilockInRead;
    decValid && decInterlockLoad ##1 decodeAdvance_r && external_flag_one;
  endsequence
  // Trap leaves decode, then leaves read into execute
  sequence trapInExec;
    decValid && decCondCallTrap ##1 decodeAdvance_r ##1 readAdvance_r;
  endsequence
  a_reset_quiet: assert property (disable iff (1'b0) !reset_n |=>
    !fetchAdvance_r && !decodeAdvance_r && !readAdvance_r)
    else $error("stage control live in reset");
  a_aux_load_stall: assert property (auxWrite ##1 auxUse |=>
    !decodeAdvance_r [*2]) else $error("aux load stall too short");
  a_flag_holds_read: assert property (ilockInRead |=>
    !readAdvance_r) else $error("read ran on flag");
  a_fetch_wait_state: assert property (fetchReq && !fetchReady |=>
    !fetchAdvance_r) else $error("fetch left before ready");
  a_block_full: assert property (blockFull |=> !fetchAdvance_r)
    else $error("fetch into full block");
  a_ext_fetch_wait: assert property (extStart |=> !fetchAdvance_r)
    else $error("fetch on busy port");
  a_dma_no_abort: assert property (fetchReq && dmaMultiActive &&
    dmaRes == fetchRes |=> !fetchAdvance_r) else $error("fetch cut dma");
  a_trap_holds_all: assert property (trapInExec |=>
    !fetchAdvance_r && !decodeAdvance_r) else $error("trap did not hold");
endmodule
bind pipeline_hazard_interlock pipeline_hazard_interlock_checker chk_i (.*);
`default_nettype wire

// ---- pipeline_hazard_interlock_tb_top.sv ----
// Self-checking bench for the pipeline interlock
`timescale 1ns/1ps
`default_nettype none
`include "interlock_consts.vh"
module pipeline_hazard_interlock_tb_top;
  logic clk_sys, reset_n, decValid, decUseValid, decIsLoop, decWriteValid;
  logic decReadValid, decDualRead, decAnyRead, decSingleStore;
  logic decDoubleStore, decInterlockLoad, decCondCallTrap, fetchReq;
  logic fetchReady, extDataDone, dmaMultiActive, external_flag_one;
  logic kickFetch, kickFlag, kickDma, kickData;
  logic [`REG_W-1:0] decUseReg, decWriteReg, decReadReg;
  logic [`RES_W-1:0] decDataResA, decDataResB, fetchRes, dmaRes;
  logic fetchAdvance_r, fetchRefetch_r, decodeAdvance_r, readAdvance_r;
  logic executeAdvance_r, decodeBubble_r, readBubble_r, executeBubble_r;
  logic decodeAddrUpdate_r, dmaGrant_r;
  int num_errors = 0;
  int n_compared = 0;
  pipeline_hazard_interlock DUT (.*);
  mem_far_side far (.*);
  initial begin
    clk_sys = 0;
    forever #2 clk_sys = ~clk_sys;
  end
  task automatic end_of_test();
    $display("compared %0d, errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    n_compared++;
    if (g !== e) begin
      num_errors++;
      $display("unexpected %s: expected %0h, seen %0h", n, e, g);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  // Quiet decode, fetch running from ROM
  task automatic idle();
    {decValid, decUseValid, decIsLoop, decWriteValid, decReadValid} = 0;
    {decDualRead, decAnyRead, decSingleStore, decDoubleStore} = 0;
    {decInterlockLoad, decCondCallTrap, kickFetch, kickFlag, kickDma} = 0;
    {decUseReg, decWriteReg, decReadReg, decDataResA, decDataResB} = 0;
    kickData = 0;
    fetchReq = 1;
    fetchRes = `RES_ROM;
  endtask
  function automatic logic pick(input int s);
    pick = (s == 0) ? fetchAdvance_r :
      (s == 1) ? decodeAdvance_r : readAdvance_r;
  endfunction
  // Bounded wait; a level never reached ends the run
  task automatic await(input string n, input int s, input logic lvl);
    for (int i = 0; i < 8 && pick(s) !== lvl; i++) step(1);
    chk(n, 8'(lvl), 8'(pick(s)));
    if (pick(s) !== lvl) end_of_test();
  endtask
  // Writer or reader, then a user; count decode stall cycles
  task automatic pair(input logic [4:0] rg, us, input logic wv, lp, int e);
    int c = 0;
    idle();
    decValid = 1;
    {decWriteValid, decWriteReg} = {wv, rg};
    {decReadValid, decReadReg} = {!wv, rg};
    step(1);
    {decWriteValid, decReadValid, decUseValid, decIsLoop} = {2'b0, !lp, lp};
    decUseReg = us;
    step(1);
    while (decodeAdvance_r !== 1'b1 && c < 8) begin
      chk("refetch in stall", 1, 8'(fetchRefetch_r));
      chk("read bubble", 1, 8'(readBubble_r));
      c++;
      step(1);
    end
    chk("decode stall cycles", 8'(e), 8'(c));
    chk("address update", 1, 8'(decodeAddrUpdate_r));
    if (c == 8) end_of_test();
    idle();
    step(3);
  endtask
  task automatic t_write_stall();
    pair(5'h01, 5'h02, 1, 0, 2);
    pair(5'h03, 5'h03, 1, 1, 2);
    pair(`REG_SP, `REG_SP, 1, 0, 2);
    pair(`REG_DP, 5'h02, 1, 0, 0);
  endtask
  task automatic t_read_stall();
    logic [4:0] r[6] = '{5'h00, `REG_IDX0, `REG_IDX1,
      `REG_BLK, `REG_DP, `REG_SP};
    foreach (r[i]) begin
      pair(r[i], (r[i] >= `REG_DP) ? r[i] : 5'h02, 0, 0,
        (r[i] <= `REG_AR_LAST || r[i] == `REG_SP) ? 1 : 0);
    end
  endtask
  task automatic t_memory();
    for (int r = 1; r <= 5; r++) begin
      idle();
      decValid = 1;
      fetchRes = 3'(r);
      decDataResA = 3'(r);
      decDataResB = (r <= `RES_ROM) ? 3'(r) : `RES_NONE;
      step(1);
      // Operands now sit in read; an external one starts its access
      kickData = (r > `RES_ROM);
      decDataResB = `RES_NONE;
      if (r > `RES_ROM) decDataResA = `RES_NONE;
      step(1);
      kickData = 0;
      chk("fetch advance", 0, 8'(fetchAdvance_r));
      step(1);
      if (r <= `RES_ROM) begin
        chk("fetch advance", 1, 8'(fetchAdvance_r));
      end else begin
        chk("execute frozen", 0, 8'(executeAdvance_r));
      end
      step(2);
    end
    idle();
    fetchRes = `RES_PRI;
    kickDma = 1;
    step(1);
    kickDma = 0;
    await("fetch under dma", 0, 0);
    chk("dma grant", 1, 8'(dmaGrant_r));
    await("fetch after dma", 0, 1);
  endtask
  task automatic t_waits();
    idle();
    kickFetch = 1;
    step(1);
    kickFetch = 0;
    await("fetch wait", 0, 0);
    chk("decode bubble", 1, 8'(decodeBubble_r));
    await("fetch ready", 0, 1);
    decValid = 1;
    decInterlockLoad = 1;
    kickFlag = 1;
    step(1);
    kickFlag = 0;
    await("read on flag", 2, 0);
    await("read released", 2, 1);
    idle();
    decValid = 1;
    decCondCallTrap = 1;
    step(1);
    // Trap holds the stages once it has reached execute
    decCondCallTrap = 0;
    step(2);
    chk("trap fetch", 0, 8'(fetchAdvance_r));
    chk("trap decode", 0, 8'(decodeAdvance_r));
    chk("trap execute", 0, 8'(executeAdvance_r));
    step(1);
    chk("trap release", 1, 8'(decodeAdvance_r));
    for (int k = 0; k < 2; k++) begin
      idle();
      step(2);
      decValid = 1;
      decSingleStore = (k == 0);
      decDoubleStore = (k == 1);
      step(1);
      {decSingleStore, decDoubleStore, decAnyRead} = 3'b001;
      decDualRead = (k == 0);
      await("read after store", 2, 0);
      chk("execute bubble", 1, 8'(executeBubble_r));
      chk("refetch on hold", 1, 8'(fetchRefetch_r));
    end
  endtask
  initial begin
    reset_n = 0;
    idle();
    step(12);
    chk("reset outputs", 0,
      8'({fetchAdvance_r, decodeAdvance_r, readAdvance_r}));
    reset_n = 1;
    step(2);
    t_write_stall();
    t_read_stall();
    t_memory();
    t_waits();
    end_of_test();
  end
endmodule
`default_nettype wire
